// ---- dch_pkg.sv ----
// package: constants and types for the two-channel dma handshake
package dch_pkg;
   // timing in ns and derived cycle counts at 100 MHz
   localparam int CLK_NS          = 10;
   localparam int READY_TMO_NS    = 2500;
   localparam int HOLD_FAST_NS    = 65;
   localparam int HOLD_SLOW_NS    = 1600;
   localparam int SETUP_NS        = 15;
   localparam int READY_TMO_CYC   = READY_TMO_NS / CLK_NS;
   localparam int HOLD_FAST_CYC   = HOLD_FAST_NS / CLK_NS;
   localparam int HOLD_SLOW_CYC   = HOLD_SLOW_NS / CLK_NS;
   localparam int SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W           = 8;
   // register offsets, per channel block of four words
   localparam logic [7:0] REG_ADDR_OFS  = 8'h00;
   localparam logic [7:0] REG_COUNT_OFS = 8'h04;
   localparam logic [7:0] REG_CTRL_OFS  = 8'h08;
   localparam logic [7:0] REG_STAT_OFS  = 8'h0C;
   localparam logic [7:0] REG_CH1_BASE  = 8'h10;
   // control field positions
   localparam int CTRL_ARM_BIT    = 0;
   localparam int CTRL_INPUT_BIT  = 1;
   localparam int CTRL_BYTE_BIT   = 2;
   localparam int CTRL_PRIO_BIT   = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   // programmed channel setup
   typedef struct packed {
      logic        arm;
      logic        input_dir;
      logic        byte_mode;
      logic        prio;
      logic [23:0] addr;
      logic [15:0] count;
   } dch_cfg_t;
   // memory side bus signals
   typedef struct packed {
      logic        address_strobe;
      logic        data_strobe;
      logic        lower_byte_strobe;
      logic        upper_byte_strobe;
      logic        read_not_write;
      logic [23:0] addr;
   } dch_mem_t;
endpackage

// ---- dch_channel.sv ----
// per-channel programmed state: address, count and arm flag
`timescale 1ns/1ps
module dch_channel (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             wr_en,
   input  wire logic [1:0]       wr_sel,
   input  wire logic [31:0]      wr_data,
   input  wire logic             step,
   output dch_pkg::dch_cfg_t     cfg
);
   import dch_pkg::*;
   // software programming and per-transfer step
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg <= '0;
      end else if (wr_en) begin
         unique case (wr_sel)
            2'h0: cfg.addr <= wr_data[23:0];
            2'h1: cfg.count <= wr_data[15:0];
            2'h2: begin
               cfg.arm       <= wr_data[CTRL_ARM_BIT];
               cfg.input_dir <= wr_data[CTRL_INPUT_BIT];
               cfg.byte_mode <= wr_data[CTRL_BYTE_BIT];
               cfg.prio      <= wr_data[CTRL_PRIO_BIT];
            end
            default: ;
         endcase
      end else if (step) begin
         // byte mode steps one byte, word mode two
         cfg.addr  <= cfg.addr + (cfg.byte_mode ? 24'h000001 : 24'h000002);
         cfg.count <= cfg.count - 16'h0001;
         if (cfg.count == 16'h0001) begin
            cfg.arm <= 1'b0;
         end
      end
   end
endmodule

// ---- dch_top.sv ----
// two-channel dma handshake engine with register port
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module dch_top (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [31:0]          reg_rdata,
   input  wire logic            dma_request_ch0_n,
   input  wire logic            dma_request_ch1_n,
   output logic                 dma_acknowledge_ch0_n,
   output logic                 dma_acknowledge_ch1_n,
   input  wire logic            card_xfer_ready_n,
   input  wire logic            memory_xfer_ack,
   input  wire logic            bus_grant,
   output logic                 bus_request,
   output logic                 bus_owned,
   output logic                 last_xfer_tag_n,
   output logic                 byte_fold_tag_n,
   output logic                 fold_to_upper,
   output dch_pkg::dch_mem_t    mem
);
   import dch_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,   // bus released
      ST_REQ   = 3'b001,   // waiting for grant
      ST_SETUP = 3'b010,   // address and direction settle
      ST_XFER  = 3'b011,   // strobes and acknowledge active
      ST_DATA  = 3'b100,   // input: data strobes after ready
      ST_END   = 3'b101,   // strobes negated, wait ready release
      ST_HOLD  = 3'b110    // keep bus for re-request window
   } dch_state_t;
   dch_state_t state;                 // sequencer state
   dch_cfg_t   cfg [2];               // per-channel setup
   logic       cur;                   // channel being served
   logic       step;                  // one transfer finished
   logic [CNT_W-1:0] tmr;             // timeout and hold timer
   logic [1:0] bus_err;               // sticky bus error per channel
   logic [1:0] req;                   // armed, pending requests
   logic       pick;                  // arbitrated channel
   logic       last;                  // current transfer is final
   logic       upper;                 // byte lives on upper lane
   logic [CNT_W-1:0] hold_lim;        // hold window for current channel
   logic       ack_on;                // acknowledge and address strobe window
   // requests count only on armed channels
   assign req[0] = ~dma_request_ch0_n & cfg[0].arm;
   assign req[1] = ~dma_request_ch1_n & cfg[1].arm;
   // higher priority wins, channel 0 on tie
   always_comb begin
      pick = 1'b0;
      if (req == 2'b10) begin
         pick = 1'b1;
      end else if (req == 2'b11 && cfg[1].prio && !cfg[0].prio) begin
         pick = 1'b1;
      end
   end
   assign last     = (cfg[cur].count == 16'h0001);
   assign upper    = cfg[cur].byte_mode & ~cfg[cur].addr[0];
   assign hold_lim = cfg[cur].prio ? CNT_W'(HOLD_SLOW_CYC) : CNT_W'(HOLD_FAST_CYC);
   // channel register files
   generate
      for (genvar g = 0; g < 2; g++) begin : g_ch
         logic sel;
         assign sel = reg_wr && (reg_addr[7:4] == 4'(g)) && (reg_addr[3:2] != 2'h3);
         dch_channel u_ch (
            .clk     (clk),
            .srst    (srst),
            .wr_en   (sel),
            .wr_sel  (reg_addr[3:2]),
            .wr_data (reg_wdata),
            .step    (step && (cur == 1'(g))),
            .cfg     (cfg[g])
         );
      end
   endgenerate
   // register reads, one cycle later
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr & 8'hEF)
            REG_ADDR_OFS:  reg_rdata <= {8'h00, cfg[reg_addr[4]].addr};
            REG_COUNT_OFS: reg_rdata <= {16'h0000, cfg[reg_addr[4]].count};
            REG_CTRL_OFS:  reg_rdata <= {28'h0, cfg[reg_addr[4]].prio,
                                         cfg[reg_addr[4]].byte_mode,
                                         cfg[reg_addr[4]].input_dir,
                                         cfg[reg_addr[4]].arm};
            REG_STAT_OFS:  reg_rdata <= {28'h0, bus_owned, (cur == reg_addr[4]),
                                         1'b0, bus_err[reg_addr[4]]};
            default:       reg_rdata <= 32'h0;          // unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end
   // bus error flags: hardware set wins over software clear
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_err <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (state == ST_XFER && tmr == CNT_W'(READY_TMO_CYC) && cur == 1'(i)) begin
               bus_err[i] <= 1'b1;
            end else if (reg_wr && reg_addr == (REG_STAT_OFS | (i != 0 ? REG_CH1_BASE : 8'h00))) begin
               bus_err[i] <= 1'b0;
            end
         end
      end
   end
   // counts once, on the edge that leaves ST_END unless aborted, so a slow memory
   // release cannot step address and count twice
   assign step = (state == ST_END) && card_xfer_ready_n && !memory_xfer_ack &&
                 !tmr[CNT_W-1];
   // sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
         cur   <= 1'b0;
         tmr   <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               tmr <= '0;
               if (req != 2'b00) begin
                  cur   <= pick;
                  state <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (bus_grant) begin
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // direction settles before strobes
               tmr <= tmr + 1'b1;
               if (tmr + 1'b1 >= CNT_W'(SETUP_CYC)) begin
                  tmr   <= '0;
                  state <= ST_XFER;
               end
            end
            ST_XFER: begin
               tmr <= tmr + 1'b1;
               if (tmr == CNT_W'(READY_TMO_CYC)) begin
                  tmr   <= {1'b1, {(CNT_W-1){1'b0}}};     // abort marker
                  state <= ST_END;
               end else if (!card_xfer_ready_n) begin
                  tmr   <= '0;
                  state <= cfg[cur].input_dir ? ST_DATA : ST_END;
               end
            end
            ST_DATA: begin
               // memory stores, then cycle ends
               if (memory_xfer_ack) begin
                  state <= ST_END;
               end
            end
            ST_END: begin
               if (card_xfer_ready_n && !memory_xfer_ack) begin
                  tmr   <= '0;
                  state <= (tmr[CNT_W-1] || last) ? ST_IDLE : ST_HOLD;
               end
            end
            ST_HOLD: begin
               tmr <= tmr + 1'b1;
               if (req[cur]) begin
                  tmr   <= '0;
                  state <= ST_SETUP;
               end else if (tmr >= hold_lim) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // bus ownership and request
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_request <= 1'b0;
         bus_owned   <= 1'b0;
      end else begin
         bus_request <= (state == ST_IDLE && req != 2'b00) || state == ST_REQ;
         bus_owned   <= !(state == ST_IDLE || state == ST_REQ ||
                          (state == ST_REQ && !bus_grant));
      end
   end
   // acknowledge window: setup end until ready (output) or memory store (input)
   assign ack_on = (state == ST_SETUP && tmr + 1'b1 >= CNT_W'(SETUP_CYC)) ||
                   (state == ST_XFER && card_xfer_ready_n &&
                    tmr != CNT_W'(READY_TMO_CYC)) ||
                   (state == ST_XFER && cfg[cur].input_dir && !card_xfer_ready_n) ||
                   (state == ST_DATA && !memory_xfer_ack);
   // memory bus drive
   always_ff @(posedge clk) begin
      if (srst) begin
         mem <= '0;
         mem.read_not_write <= 1'b1;
      end else begin
         mem.addr           <= cfg[cur].addr;
         mem.read_not_write <= !cfg[cur].input_dir;
         // strobe and acknowledge rise together
         mem.address_strobe <= ack_on;
         mem.data_strobe    <= 1'b0;
         mem.lower_byte_strobe <= 1'b0;
         mem.upper_byte_strobe <= 1'b0;
         if ((state == ST_SETUP && tmr + 1'b1 >= CNT_W'(SETUP_CYC) && !cfg[cur].input_dir) ||
             (state == ST_XFER && !cfg[cur].input_dir && card_xfer_ready_n &&
              tmr != CNT_W'(READY_TMO_CYC)) ||
             (state == ST_XFER && cfg[cur].input_dir && !card_xfer_ready_n) ||
             (state == ST_DATA && !memory_xfer_ack)) begin
            mem.data_strobe       <= 1'b1;
            mem.lower_byte_strobe <= !cfg[cur].byte_mode || !upper;
            mem.upper_byte_strobe <= !cfg[cur].byte_mode || upper;
         end
      end
   end
   // acknowledge, last and fold tags share one timing
   always_ff @(posedge clk) begin
      if (srst) begin
         dma_acknowledge_ch0_n <= 1'b1;
         dma_acknowledge_ch1_n <= 1'b1;
         last_xfer_tag_n       <= 1'b1;
         byte_fold_tag_n       <= 1'b1;
         fold_to_upper         <= 1'b0;
      end else begin
         dma_acknowledge_ch0_n <= !(ack_on && cur == 1'b0);
         dma_acknowledge_ch1_n <= !(ack_on && cur == 1'b1);
         last_xfer_tag_n       <= !(ack_on && last);
         byte_fold_tag_n       <= !(ack_on && upper);
         fold_to_upper         <= ack_on && upper && cfg[cur].input_dir;
      end
   end
   // acknowledge never without address strobe
   a_ack_strobe: assert property (@(posedge clk) disable iff (srst)
      !dma_acknowledge_ch0_n |-> mem.address_strobe)
      else $error("ack without address strobe");
   // same for the second channel
   a_ack1_strobe: assert property (@(posedge clk) disable iff (srst)
      !dma_acknowledge_ch1_n |-> mem.address_strobe)
      else $error("ack1 without address strobe");
   // address strobe only while the bus is ours
   a_strobe_owned: assert property (@(posedge clk) disable iff (srst)
      mem.address_strobe |-> bus_owned)
      else $error("address strobe without bus");
   // ready ends acknowledge within two cycles on output
   a_ready_ends: assert property (@(posedge clk) disable iff (srst)
      (!dma_acknowledge_ch0_n && !card_xfer_ready_n && mem.read_not_write)
      |-> ##[1:2] dma_acknowledge_ch0_n)
      else $error("ack not ended by ready");
   // same for the second channel
   a_ready_ends1: assert property (@(posedge clk) disable iff (srst)
      (!dma_acknowledge_ch1_n && !card_xfer_ready_n && mem.read_not_write)
      |-> ##[1:2] dma_acknowledge_ch1_n)
      else $error("ack1 not ended by ready");
   // cycle fully off: address strobe and both acknowledges negated
   sequence s_cycle_off;
      !mem.address_strobe && dma_acknowledge_ch0_n && dma_acknowledge_ch1_n;
   endsequence
   // input store ends the cycle on memory acknowledge
   a_data_end: assert property (@(posedge clk) disable iff (srst)
      (state == ST_DATA && memory_xfer_ack) |=> s_cycle_off)
      else $error("cycle not ended by memory store");
   // input direction settled low before the acknowledge rises
   a_rnw_input: assert property (@(posedge clk) disable iff (srst)
      ($fell(dma_acknowledge_ch0_n && dma_acknowledge_ch1_n) && !mem.read_not_write)
      |-> !$past(mem.read_not_write))
      else $error("write direction late");
   // output strobes data with the acknowledge
   a_out_strobes: assert property (@(posedge clk) disable iff (srst)
      (!(dma_acknowledge_ch0_n && dma_acknowledge_ch1_n) && mem.read_not_write)
      |-> mem.data_strobe)
      else $error("output ack without data strobe");
   // fold buffer to upper lane only on tagged input
   a_fold_input: assert property (@(posedge clk) disable iff (srst)
      fold_to_upper |-> (!byte_fold_tag_n && !mem.read_not_write))
      else $error("fold buffer misused");
   // last tag only with an acknowledge
   a_last_tag: assert property (@(posedge clk) disable iff (srst)
      !last_xfer_tag_n |-> (!dma_acknowledge_ch0_n || !dma_acknowledge_ch1_n))
      else $error("last tag without ack");
   // word mode strobes both lanes
   a_word_lanes: assert property (@(posedge clk) disable iff (srst)
      (mem.data_strobe && !cfg[cur].byte_mode) |->
      (mem.lower_byte_strobe && mem.upper_byte_strobe))
      else $error("word strobe lanes wrong");
   // fold tag only on a byte transfer
   a_fold_byte: assert property (@(posedge clk) disable iff (srst)
      !byte_fold_tag_n |-> !(mem.lower_byte_strobe && mem.upper_byte_strobe))
      else $error("fold on word transfer");
   // never both acknowledges
   a_one_ack: assert property (@(posedge clk) disable iff (srst)
      !(!dma_acknowledge_ch0_n && !dma_acknowledge_ch1_n))
      else $error("both acks active");
   // timeout raises bus error
   a_tmo_err: assert property (@(posedge clk) disable iff (srst)
      (state == ST_XFER && tmr == CNT_W'(READY_TMO_CYC)) |=> bus_err[cur])
      else $error("timeout without bus error");
   // timeout gives the bus back within a few cycles
   a_err_idle: assert property (@(posedge clk) disable iff (srst)
      (state == ST_XFER && tmr == CNT_W'(READY_TMO_CYC)) |-> ##[1:8] (state == ST_IDLE))
      else $error("bus kept after timeout");
   // final transfer disarms its channel
   a_count_done: assert property (@(posedge clk) disable iff (srst)
      (step && last) |=> !cfg[cur].arm)
      else $error("channel armed after final transfer");
   // with both channels disarmed the sequencer never leaves idle
   a_disarm: assert property (@(posedge clk) disable iff (srst)
      (state == ST_IDLE && !cfg[0].arm && !cfg[1].arm) |=> state == ST_IDLE)
      else $error("request served while disarmed");
endmodule

// ---- dch_card_model.sv ----
// far-side model: card on both channels, memory device and bus arbiter
`timescale 1ns/1ps
module dch_card_model (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic [1:0]    req_en,
   input  wire logic          no_ready,
   input  wire logic          dma_acknowledge_ch0_n,
   input  wire logic          dma_acknowledge_ch1_n,
   input  dch_pkg::dch_mem_t  mem,
   input  wire logic          bus_request,
   output logic               dma_request_ch0_n,
   output logic               dma_request_ch1_n,
   output logic               card_xfer_ready_n,
   output logic               memory_xfer_ack,
   output logic               bus_grant
);
   import dch_pkg::*;
   logic [3:0] mem_cnt;  // cycles of memory data strobes
   logic [3:0] rdy_cnt;  // cycles since card may answer
   logic       acked;    // either channel acknowledged
   assign acked = !dma_acknowledge_ch0_n || !dma_acknowledge_ch1_n;
   // request level held low while wanted, kept through acknowledge
   assign dma_request_ch0_n = !req_en[0];
   assign dma_request_ch1_n = !req_en[1];
   // arbiter grants one cycle after the request
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_grant <= 1'b0;
      end else begin
         bus_grant <= bus_request;
      end
   end
   // memory answers two cycles into its data strobes, drops with address strobe
   always_ff @(posedge clk) begin
      if (srst || !mem.address_strobe) begin
         mem_cnt         <= 4'h0;
         memory_xfer_ack <= 1'b0;
      end else if (mem.lower_byte_strobe || mem.upper_byte_strobe) begin
         mem_cnt         <= mem_cnt + 4'h1;
         memory_xfer_ack <= (mem_cnt >= 4'h1);
      end
   end
   // card ready: output waits memory acknowledge, released once acknowledge is gone
   always_ff @(posedge clk) begin
      if (srst || !acked) begin
         rdy_cnt           <= 4'h0;
         card_xfer_ready_n <= 1'b1;
      // ready answers only its acknowledge, slave cycles stay free between transfers
      end else if (!no_ready && (!mem.read_not_write || memory_xfer_ack)) begin
         rdy_cnt <= rdy_cnt + 4'h1;
         if (rdy_cnt >= 4'h1) begin
            card_xfer_ready_n <= 1'b0;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// testbench for the two-channel dma handshake engine
`timescale 1ns/1ps
module tb_top;
   import dch_pkg::*;
   logic        clk, srst, reg_wr, reg_rd, no_ready, bus_grant, bus_request, bus_owned;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [1:0]  req_en;
   logic        req0_n, req1_n, ack0_n, ack1_n, rdy_n, mem_ack;
   logic        last_n, fold_n, fold_to_upper, ack_prev;
   dch_mem_t    mem;
   logic [31:0] snap [0:15];  // bus state at each acknowledge start
   int          nsnap, bad_count, checked, cyc;
   dch_top i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dma_request_ch0_n(req0_n), .dma_request_ch1_n(req1_n),
      .dma_acknowledge_ch0_n(ack0_n), .dma_acknowledge_ch1_n(ack1_n),
      .card_xfer_ready_n(rdy_n), .memory_xfer_ack(mem_ack), .bus_grant(bus_grant),
      .bus_request(bus_request), .bus_owned(bus_owned), .last_xfer_tag_n(last_n),
      .byte_fold_tag_n(fold_n), .fold_to_upper(fold_to_upper), .mem(mem));
   dch_card_model i_card (.clk(clk), .srst(srst), .req_en(req_en), .no_ready(no_ready),
      .dma_acknowledge_ch0_n(ack0_n), .dma_acknowledge_ch1_n(ack1_n), .mem(mem),
      .bus_request(bus_request), .dma_request_ch0_n(req0_n), .dma_request_ch1_n(req1_n),
      .card_xfer_ready_n(rdy_n), .memory_xfer_ack(mem_ack), .bus_grant(bus_grant));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   // closing report
   task automatic end_sim();
      $display("bad_count=%0d checked=%0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // packed view of a transfer start
   function automatic logic [31:0] sx(input logic ch, rnw, ls, us, ds, ln, fn,
                                      input logic [23:0] a);
      return {1'b0, ch, rnw, ls, us, ds, ln, fn, a};
   endfunction
   // register port write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // register port read, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // program a channel, arm written last
   task automatic setup(input logic ch, input logic [23:0] a, input logic [15:0] n,
                        input logic [3:0] ctl);
      logic [7:0] b;
      b = ch ? REG_CH1_BASE : 8'h00;
      wr(b + REG_ADDR_OFS, {8'h00, a});
      wr(b + REG_COUNT_OFS, {16'h0000, n});
      wr(b + REG_CTRL_OFS, {28'h0000000, ctl});
   endtask
   // wait for n transfers and the bus to go idle
   task automatic wait_snaps(input int n);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         #1;
         if (nsnap >= n && !bus_owned && ack0_n && ack1_n) break;
      end
      chk(nsnap, n);
   endtask
   // snapshot each transfer start; strobe, acknowledge and tag move together
   always @(posedge clk) begin
      if (srst) begin
         nsnap    = 0;
         ack_prev = 1'b1;
      end else begin
         if (ack_prev && !(ack0_n && ack1_n)) begin
            snap[nsnap] = sx(!ack1_n, mem.read_not_write, mem.lower_byte_strobe,
               mem.upper_byte_strobe, mem.data_strobe, last_n, fold_n, mem.addr)
               | {fold_to_upper, 31'h0};
            nsnap++;
         end
         ack_prev = ack0_n && ack1_n;
         chk({31'h0, mem.address_strobe}, {31'h0, !(ack0_n && ack1_n)});
         if (!last_n) chk({31'h0, ack0_n && ack1_n}, 32'h0);
      end
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
      req_en = 2'b00; no_ready = 1'b0; bad_count = 0; checked = 0; cyc = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk({ack0_n, ack1_n, last_n, fold_n, mem.read_not_write, mem.address_strobe,
           mem.data_strobe, mem.lower_byte_strobe, mem.upper_byte_strobe, bus_owned},
          32'h3E0);
      rd(REG_CTRL_OFS, v);
      chk(v, {28'h0, CTRL_RST});
      wr(REG_ADDR_OFS, 32'h00FEDCBA);
      wr(REG_COUNT_OFS, 32'h0000FFFF);
      rd(REG_ADDR_OFS, v);
      chk(v, 32'h00FEDCBA);
      rd(REG_COUNT_OFS, v);
      chk(v, 32'h0000FFFF);
      rd(8'h20, v);
      chk(v, 32'h0);
      // output word, single transfer, then requests ignored
      setup(1'b0, 24'h000100, 16'h1, 4'h1);
      req_en <= 2'b01;
      wait_snaps(1);
      chk(snap[0], sx(0, 1, 1, 1, 1, 0, 1, 24'h000100));
      rd(REG_CTRL_OFS, v);
      chk(v & 32'h1, 32'h0);
      repeat (40) @(posedge clk);
      chk(nsnap, 1);
      chk({31'h0, bus_owned}, 32'h0);
      req_en <= 2'b00;
      // byte output burst on channel 1: upper lane folded, then lower lane
      setup(1'b1, 24'h000200, 16'h2, 4'h5);
      req_en <= 2'b10;
      wait_snaps(3);
      req_en <= 2'b00;
      chk(snap[1], sx(1, 1, 0, 1, 1, 1, 0, 24'h000200));
      chk(snap[2], sx(1, 1, 1, 0, 1, 0, 1, 24'h000201));
      // input word: write direction before the strobe
      setup(1'b0, 24'h000300, 16'h1, 4'h3);
      req_en <= 2'b01;
      wait_snaps(4);
      req_en <= 2'b00;
      chk(snap[3] & 32'hE3FFFFFF, sx(0, 0, 0, 0, 0, 0, 1, 24'h000300));
      // equal priority: channel 0 first
      setup(1'b0, 24'h000400, 16'h1, 4'h1);
      setup(1'b1, 24'h000500, 16'h1, 4'h1);
      req_en <= 2'b11;
      wait_snaps(6);
      req_en <= 2'b00;
      chk({30'h0, snap[4][30], snap[5][30]}, 32'h1);
      // channel 1 with priority set wins
      setup(1'b0, 24'h000400, 16'h1, 4'h1);
      setup(1'b1, 24'h000500, 16'h1, 4'h9);
      req_en <= 2'b11;
      wait_snaps(8);
      req_en <= 2'b00;
      chk({30'h0, snap[6][30], snap[7][30]}, 32'h2);
      // input byte to an even address: upper lane through the fold buffer
      setup(1'b1, 24'h000700, 16'h1, 4'h7);
      req_en <= 2'b10;
      wait_snaps(9);
      req_en <= 2'b00;
      chk(snap[8], sx(1, 0, 0, 0, 0, 0, 0, 24'h000700) | 32'h80000000);
      // card never ready: bus error, abort, release, then clear
      no_ready <= 1'b1;
      setup(1'b0, 24'h000600, 16'h1, 4'h1);
      req_en <= 2'b01;
      for (int i = 0; i < 100 && nsnap < 10; i++) @(posedge clk);
      req_en <= 2'b00;
      repeat (READY_TMO_CYC + 20) @(posedge clk);
      rd(REG_STAT_OFS, v);
      chk(v & 32'h9, 32'h1);
      chk({31'h0, ack0_n}, 32'h1);
      wr(REG_STAT_OFS, 32'h1);
      rd(REG_STAT_OFS, v);
      chk(v & 32'h1, 32'h0);
      no_ready <= 1'b0;
      end_sim();
   end
endmodule
